// ===== fault_monitor_map.svh
// Register offsets, field positions, reset values and timing counts for the fault monitor
`ifndef FAULT_MONITOR_MAP_SVH
`define FAULT_MONITOR_MAP_SVH
`define FM_OFS_CTRL 12'h000
`define FM_OFS_FLAGS 12'h004
`define FM_OFS_CLEAR 12'h008
`define FM_OFS_LIVE 12'h00c
`define FM_CTRL_STANDBY 0
`define FM_CTRL_LOWSUP_LSB 8
`define FM_CTRL_LOWSUP_W 5
`define FM_CLR_FAULT 0
`define FM_CLR_POWERON 1
`define FM_LOWSUP_RESET 5'h00
`define FM_LOWSUP_MAX 5'h1f
`define FM_LOWSUP_MIN_V 4
`define FM_LOWSUP_MAX_V 35
`define FM_PULSE_NS 50000
`define FM_CLK_NS 25
`define FM_PULSE_CYC ((`FM_PULSE_NS) / (`FM_CLK_NS))
`endif

// ===== fault_monitor_pkg.sv
// Types shared by the fault monitor
package fault_monitor_pkg;
  typedef struct packed {
    logic thermal_shutdown;
    logic overtemperature;
    logic thermal_warning;
    logic ref_short;
    logic ref_open;
    logic supply_undervolt;
    logic low_supply;
    logic lockout;
  } fault_in_s;
  typedef struct packed {
    logic error_summary;
    logic poweron;
    logic overtemperature;
    logic thermal_warning;
    logic reference;
    logic supply_undervolt;
    logic low_supply;
  } flags_s;
  typedef enum logic [1:0] {
    ST_POR = 2'b00,
    ST_INIT = 2'b01,
    ST_NORMAL = 2'b11
  } power_state_e;
endpackage : fault_monitor_pkg

// ===== normal_state_fault_monitor.sv
// Fault supervision, fault pin driver and standby output with an APB register slave
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "fault_monitor_map.svh"
// Functional notes
// - Standby pull-up on by default, off while standby bit is 1, on again at 0.
// - Standby output high after enable; low when standby bit set or device disabled.
// - Normal state only reports faults, except lockout, undervoltage, overtemperature, thermal shutdown and low supply.
// - Lockout enters power-on reset; recovery goes to init with power-on and summary set.
// - Writing power-on clear bit clears power-on and summary flags; bit self-clears.
// - Supply below low threshold gives one 50 us pin pulse and sets flags.
// - Low-supply flag latched; fault clear after recovery clears it and summary.
// - Open and single-LED short detection disabled while supply is below low threshold.
// - Low-supply threshold selects 4 V to 35 V in 1 V steps.
// - Supply undervoltage holds fault pin low constantly and sets flags.
// - Outputs disabled under falling undervoltage threshold, enabled above rising one.
// - Undervoltage flag latched until fault clear, which also clears summary.
// - Reference open or short holds fault pin low and sets reference and summary.
// - Pin released on reference recovery; flags held until fault clear.
// - Thermal warning gives one 50 us pin pulse and sets flags.
// - Thermal-warning flag latched; fault clear clears it and summary.
// - Overtemperature turns outputs off, holds pin low, sets flags.
// - Below hysteresis outputs resume, pin released; flags kept until fault clear.
// - Shutdown temperature kills regulator, sets power-on flags, restarts from reset defaults.
module normal_state_fault_monitor #(
  parameter int PULSE_CYC = `FM_PULSE_CYC
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Analog comparator results and enable pin, asynchronous
  input wire fault_monitor_pkg::fault_in_s fault_raw_i,
  input wire logic device_enable_i,
  // Pins and controls toward the analog side
  output logic err_sink_oe_o,
  output logic err_sink_o,
  output logic transceiver_standby_out_o,
  output logic standby_pullup_en_o,
  output logic outputs_enable_o,
  output logic regulator_rail_en_o,
  output logic open_short_detect_en_o,
  output logic [4:0] low_supply_threshold_o
);
  import fault_monitor_pkg::*;

  localparam int PCW = $clog2(PULSE_CYC + 1);

  logic rst_sync1;
  logic rst_sync2;
  fault_in_s sync1;
  fault_in_s sync2;
  fault_in_s sync3;
  fault_in_s live;
  fault_in_s live_d;
  logic en_s1;
  logic en_s2;
  logic en_s3;
  logic en_live;
  flags_s flags;
  power_state_e state;
  logic standby;
  logic [4:0] low_supply_threshold;
  logic [PCW-1:0] pulse_cnt;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic clr_fault;
  logic clr_poweron;
  logic soft_reset;
  logic pulse_fire;
  logic constant_sink;
  // Event strobes, one cycle each; ref_bad is a level
  logic low_rise;
  logic uv_rise;
  logic ref_bad;
  logic ref_rise;
  logic warn_rise;
  logic ot_rise;
  logic ctrl_wr;
  logic clear_wr;

  function automatic logic rose(input logic now, input logic was);
    rose = now & ~was;
  endfunction : rose

  function automatic logic clr_ok(input logic clr, input logic cond);
    clr_ok = clr & ~cond;
  endfunction : clr_ok

  // Reset release through two flops
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync1 <= 1'b0;
      rst_sync2 <= 1'b0;
    end else begin
      rst_sync1 <= 1'b1;
      rst_sync2 <= rst_sync1;
    end
  end

  // Three-stage input capture; a change counts once stages two and three agree
  always_ff @(posedge core_clk_i or negedge rst_sync2) begin
    if (!rst_sync2) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      live <= '0;
      en_s1 <= 1'b0;
      en_s2 <= 1'b0;
      en_s3 <= 1'b0;
      en_live <= 1'b0;
    end else begin
      sync1 <= fault_raw_i;
      sync2 <= sync1;
      sync3 <= sync2;
      for (int i = 0; i < $bits(fault_in_s); i++) begin
        if (sync2[i] == sync3[i]) begin
          live[i] <= sync3[i];
        end
      end
      en_s1 <= device_enable_i;
      en_s2 <= en_s1;
      en_s3 <= en_s2;
      if (en_s2 == en_s3) begin
        en_live <= en_s3;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_sync2) begin
    if (!rst_sync2) begin
      live_d <= '0;
    end else begin
      live_d <= live;
    end
  end

  // Lockout or thermal shutdown drop to power-on reset; control register returns to defaults
  always_ff @(posedge core_clk_i or negedge rst_sync2) begin
    if (!rst_sync2) begin
      state <= ST_POR;
    end else begin
      // INIT lasts one cycle; nothing is loaded from storage here
      case (state)
        ST_POR: begin
          if (!live.lockout && !live.thermal_shutdown) begin
            state <= ST_INIT;
          end
        end
        ST_INIT: begin
          if (live.lockout || live.thermal_shutdown) begin
            state <= ST_POR;
          end else begin
            state <= ST_NORMAL;
          end
        end
        ST_NORMAL: begin
          if (live.lockout || live.thermal_shutdown) begin
            state <= ST_POR;
          end
        end
        default: begin
          state <= ST_POR;
        end
      endcase
    end
  end

  assign soft_reset = (state == ST_POR);

  // APB decode: reads captured in setup, writes land at the access edge with ready high
  assign addr_ok = (paddr_i == `FM_OFS_CTRL) || (paddr_i == `FM_OFS_FLAGS) ||
                   (paddr_i == `FM_OFS_CLEAR) || (paddr_i == `FM_OFS_LIVE);
  assign wr_en = psel_i & penable_i & pready_o & pwrite_i & addr_ok;
  assign rd_en = psel_i & ~penable_i & ~pwrite_i;
  assign ctrl_wr = wr_en & (paddr_i == `FM_OFS_CTRL);
  assign clear_wr = wr_en & (paddr_i == `FM_OFS_CLEAR) & pstrb_i[0];
  // Clear strobes last one cycle, so the bits read back as zero
  assign clr_fault = clear_wr & pwdata_i[`FM_CLR_FAULT];
  assign clr_poweron = clear_wr & pwdata_i[`FM_CLR_POWERON];

  // Rising edges only, so a fault that stays does not set its flag again after a clear
  assign ref_bad = live.ref_open | live.ref_short;
  assign low_rise = rose(live.low_supply, live_d.low_supply);
  assign uv_rise = rose(live.supply_undervolt, live_d.supply_undervolt);
  assign ref_rise = rose(ref_bad, live_d.ref_open | live_d.ref_short);
  assign warn_rise = rose(live.thermal_warning, live_d.thermal_warning);
  assign ot_rise = rose(live.overtemperature, live_d.overtemperature);

  always_ff @(posedge core_clk_i or negedge rst_sync2) begin
    if (!rst_sync2) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~addr_ok;
      prdata_o <= 32'h0000_0000;
      if (rd_en) begin
        case (paddr_i)
          `FM_OFS_CTRL: begin
            prdata_o <= {19'h0, low_supply_threshold, 7'h00, standby};
          end
          `FM_OFS_FLAGS: begin
            prdata_o <= {25'h0, flags};
          end
          `FM_OFS_LIVE: begin
            prdata_o <= {22'h0, state, live};
          end
          default: begin
            prdata_o <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // Control register; write lands at the access edge
  always_ff @(posedge core_clk_i or negedge rst_sync2) begin
    if (!rst_sync2) begin
      standby <= 1'b0;
      low_supply_threshold <= `FM_LOWSUP_RESET;
    end else if (soft_reset) begin
      standby <= 1'b0;
      low_supply_threshold <= `FM_LOWSUP_RESET;
    end else if (ctrl_wr) begin
      if (pstrb_i[0]) begin
        standby <= pwdata_i[`FM_CTRL_STANDBY];
      end
      if (pstrb_i[1]) begin
        // Codes past 35 V saturate so the analog side never sees an undefined step
        if (pwdata_i[`FM_CTRL_LOWSUP_LSB +: `FM_CTRL_LOWSUP_W] >
            5'(`FM_LOWSUP_MAX_V - `FM_LOWSUP_MIN_V)) begin
          low_supply_threshold <= 5'(`FM_LOWSUP_MAX_V - `FM_LOWSUP_MIN_V);
        end else begin
          low_supply_threshold <= pwdata_i[`FM_CTRL_LOWSUP_LSB +: `FM_CTRL_LOWSUP_W];
        end
      end
    end
  end

  // Sticky flags; set beats clear, clear ignored while the condition stays, except for the summary
  always_ff @(posedge core_clk_i or negedge rst_sync2) begin
    if (!rst_sync2) begin
      flags <= '0;
    end else begin
      if (low_rise) begin
        flags.low_supply <= 1'b1;
      end else if (clr_ok(clr_fault, live.low_supply)) begin
        flags.low_supply <= 1'b0;
      end
      if (uv_rise) begin
        flags.supply_undervolt <= 1'b1;
      end else if (clr_ok(clr_fault, live.supply_undervolt)) begin
        flags.supply_undervolt <= 1'b0;
      end
      if (ref_rise) begin
        flags.reference <= 1'b1;
      end else if (clr_ok(clr_fault, ref_bad)) begin
        flags.reference <= 1'b0;
      end
      if (warn_rise) begin
        flags.thermal_warning <= 1'b1;
      end else if (clr_ok(clr_fault, live.thermal_warning)) begin
        flags.thermal_warning <= 1'b0;
      end
      if (ot_rise) begin
        flags.overtemperature <= 1'b1;
      end else if (clr_ok(clr_fault, live.overtemperature)) begin
        flags.overtemperature <= 1'b0;
      end
      if (state == ST_POR) begin
        flags.poweron <= 1'b1;
      end else if (clr_poweron) begin
        flags.poweron <= 1'b0;
      end
      // Summary follows any new event; each clear also drops it
      if (state == ST_POR || low_rise || uv_rise || ref_rise || warn_rise ||
          ot_rise) begin
        flags.error_summary <= 1'b1;
      end else if (clr_fault || clr_poweron) begin
        flags.error_summary <= 1'b0;
      end
    end
  end

  // Pulse timer for warning-class events
  assign pulse_fire = low_rise | warn_rise;
  assign constant_sink = live.supply_undervolt | ref_bad |
                         live.overtemperature | live.thermal_shutdown;

  always_ff @(posedge core_clk_i or negedge rst_sync2) begin
    if (!rst_sync2) begin
      pulse_cnt <= '0;
    end else if (pulse_fire) begin
      // Loaded one short: the firing cycle itself already drives the pin
      pulse_cnt <= PCW'(PULSE_CYC - 1);
    end else if (pulse_cnt != '0) begin
      pulse_cnt <= pulse_cnt - PCW'(1);
    end
  end

  // Pin and analog controls, all registered
  always_ff @(posedge core_clk_i or negedge rst_sync2) begin
    if (!rst_sync2) begin
      err_sink_oe_o <= 1'b0;
      err_sink_o <= 1'b0;
      transceiver_standby_out_o <= 1'b0;
      standby_pullup_en_o <= 1'b1;
      outputs_enable_o <= 1'b0;
      regulator_rail_en_o <= 1'b1;
      open_short_detect_en_o <= 1'b0;
      low_supply_threshold_o <= `FM_LOWSUP_RESET;
    end else begin
      // Open drain: only ever drives low; reference recovery releases by itself
      err_sink_oe_o <= constant_sink | (pulse_cnt != '0) | pulse_fire;
      err_sink_o <= 1'b0;
      standby_pullup_en_o <= ~standby;
      transceiver_standby_out_o <= en_live & ~standby;
      // Only leaving normal state, undervoltage and overtemperature act; reference faults are left to the host
      outputs_enable_o <= (state == ST_NORMAL) & ~live.supply_undervolt &
                          ~live.overtemperature;
      regulator_rail_en_o <= ~live.thermal_shutdown;
      open_short_detect_en_o <= ~live.low_supply;
      low_supply_threshold_o <= low_supply_threshold;
    end
  end
endmodule : normal_state_fault_monitor
`default_nettype wire

// ===== fault_monitor_asserts.sv
// Port-level assertion checker for the fault monitor
`timescale 1ns/1ps
`default_nettype none
module fault_monitor_asserts #(
  parameter int PULSE_CYC = 10
) (
  // Clock, reset and bus
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  // Faults and pins
  input wire fault_monitor_pkg::fault_in_s fault_raw_i,
  input wire logic device_enable_i,
  input wire logic err_sink_oe_o,
  input wire logic transceiver_standby_out_o,
  input wire logic standby_pullup_en_o,
  input wire logic outputs_enable_o,
  input wire logic regulator_rail_en_o,
  input wire logic open_short_detect_en_o
);
  import fault_monitor_pkg::*;
  logic steady;
  int sink_run;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  // Constant-sink faults may hold the pin for ever, so they restart the run
  assign steady = (fault_raw_i & 8'hdd) == 8'h00;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sink_run <= 0;
    end else if (!err_sink_oe_o || !steady) begin
      sink_run <= 0;
    end else begin
      sink_run <= sink_run + 1;
    end
  end
  a_pulse_length_bound: assert property (sink_run <= PULSE_CYC + 8)
    else $error("fault pin pulse ran too long");
  a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready after setup");
  a_pullup_off_low: assert property (!standby_pullup_en_o |-> !transceiver_standby_out_o)
    else $error("standby high with pull-up off");
  a_disabled_standby_low: assert property (!device_enable_i [*8] |-> !transceiver_standby_out_o)
    else $error("standby high while disabled");
  a_uv_sink_off: assert property (fault_raw_i.supply_undervolt [*8] |-> err_sink_oe_o && !outputs_enable_o)
    else $error("undervoltage not acted on");
  a_ot_sink_off: assert property (fault_raw_i.overtemperature [*8] |-> err_sink_oe_o && !outputs_enable_o)
    else $error("overtemperature not acted on");
  a_ref_sink_hold: assert property ((fault_raw_i.ref_open || fault_raw_i.ref_short) [*8] |-> err_sink_oe_o)
    else $error("reference fault pin not held");
  a_low_detect_off: assert property (fault_raw_i.low_supply [*8] |-> !open_short_detect_en_o)
    else $error("detection left on in low supply");
  a_tsd_rail_off: assert property (fault_raw_i.thermal_shutdown [*8] |-> !regulator_rail_en_o)
    else $error("rail left on in shutdown");
  c_pulse_seen: cover property ($rose(err_sink_oe_o) && steady);
  c_standby_low: cover property (!standby_pullup_en_o);
  c_uv_off: cover property (fault_raw_i.supply_undervolt && !outputs_enable_o);
endmodule : fault_monitor_asserts
bind normal_state_fault_monitor fault_monitor_asserts #(.PULSE_CYC(PULSE_CYC)) i_fault_monitor_asserts (
  .core_clk_i, .rst_b_i, .psel_i, .penable_i, .pready_o, .fault_raw_i, .device_enable_i, .err_sink_oe_o,
  .transceiver_standby_out_o, .standby_pullup_en_o, .outputs_enable_o, .regulator_rail_en_o,
  .open_short_detect_en_o);
`default_nettype wire

// ===== fault_pins_model.sv
// Pin level model of the fault line and the transceiver standby input
`timescale 1ns/1ps
`default_nettype none
module fault_pins_model (
  // Design side
  input wire logic err_sink_oe_i,
  input wire logic err_sink_i,
  input wire logic transceiver_standby_out_i,
  input wire logic standby_pullup_en_i,
  input wire logic regulator_rail_en_i,
  // Levels seen by host and transceiver
  output logic err_pin_o,
  output logic standby_pin_o
);
  // Host pull-up holds the line high while nobody sinks
  assign err_pin_o = err_sink_oe_i ? err_sink_i : 1'b1;
  // External pull-down wins once pull-up or rail is off
  assign standby_pin_o = transceiver_standby_out_i && standby_pullup_en_i && regulator_rail_en_i;
endmodule : fault_pins_model
`default_nettype wire

// ===== test_normal_state_fault_monitor.sv
// Self-checking bench for the normal state fault monitor
`timescale 1ns/1ps
`default_nettype none
`include "fault_monitor_map.svh"
module test_normal_state_fault_monitor;
  import fault_monitor_pkg::*;
  // Short pulse keeps the run brief
  localparam int PC = 10;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic en = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [4:0] thr;
  logic pready, pslverr, oe, sink, stb, pull, outs, rail, osd, err_pin, stb_pin;
  fault_in_s raw = '0;
  int miscompares = 0;
  int n_compared = 0;
  // Fault bit, flag bit, pulsed, outputs forced off
  int fbit[6] = '{1, 5, 2, 3, 4, 6};
  int flag[6] = '{0, 3, 1, 2, 2, 4};
  logic pulsed[6] = '{1, 1, 0, 0, 0, 0};
  logic off[6] = '{0, 0, 1, 0, 0, 1};
  always #12.5 clk = ~clk;
  normal_state_fault_monitor #(.PULSE_CYC(PC)) i_normal_state_fault_monitor (
    .core_clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .fault_raw_i(raw), .device_enable_i(en), .err_sink_oe_o(oe), .err_sink_o(sink),
    .transceiver_standby_out_o(stb), .standby_pullup_en_o(pull), .outputs_enable_o(outs),
    .regulator_rail_en_o(rail), .open_short_detect_en_o(osd), .low_supply_threshold_o(thr));
  fault_pins_model i_fault_pins_model (.err_sink_oe_i(oe), .err_sink_i(sink), .transceiver_standby_out_i(stb),
    .standby_pullup_en_i(pull), .regulator_rail_en_i(rail), .err_pin_o(err_pin), .standby_pin_o(stb_pin));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
  endtask : rd
  task automatic give_verdict;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict
  initial begin
    cyc(20000);
    miscompares++;
    give_verdict();
  end
  initial begin
    logic [31:0] q;
    logic e;
    int n;
    cyc(8);
    rst_b <= 1'b1;
    cyc(10);
    chk(32'({pull, stb, stb_pin}), 32'h7);
    rd(`FM_OFS_CTRL, 32'h0);
    rd(`FM_OFS_FLAGS, 32'h60);
    rd(`FM_OFS_LIVE, 32'h300);
    wr(`FM_OFS_CLEAR, 32'h2);
    rd(`FM_OFS_FLAGS, 32'h0);
    rd(`FM_OFS_CLEAR, 32'h0);
    $display("test reset done");
    wr(`FM_OFS_CTRL, 32'h1);
    cyc(2);
    chk(32'({pull, stb, stb_pin}), 32'h0);
    wr(`FM_OFS_CTRL, 32'h0);
    cyc(2);
    chk(32'({pull, stb, stb_pin}), 32'h7);
    en <= 1'b0;
    cyc(8);
    chk(32'({stb, stb_pin}), 32'h0);
    en <= 1'b1;
    cyc(8);
    chk(32'({stb, stb_pin}), 32'h3);
    for (int c = 1; c < 32; c += 30) begin
      wr(`FM_OFS_CTRL, 32'(c) << 8);
      cyc(2);
      chk(32'(thr), 32'(c));
      rd(`FM_OFS_CTRL, 32'(c) << 8);
    end
    apb(1'b0, 12'h010, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1);
    wr(`FM_OFS_FLAGS, 32'h7f);
    rd(`FM_OFS_FLAGS, 32'h0);
    $display("test standby and bus done");
    for (int k = 0; k < 6; k++) begin
      raw <= fault_in_s'(8'h1 << fbit[k]);
      n = 0;
      repeat (40) begin
        @(posedge clk);
        n += int'(oe);
      end
      if (pulsed[k]) chk(32'(n), 32'(PC));
      else chk(32'({oe, err_pin}), 32'h2);
      chk(32'({outs, osd}), 32'({!off[k], fbit[k] != 1}));
      rd(`FM_OFS_FLAGS, 32'h40 | (32'h1 << flag[k]));
      wr(`FM_OFS_CLEAR, 32'h1);
      rd(`FM_OFS_FLAGS, 32'h1 << flag[k]);
      raw <= '0;
      cyc(10);
      chk(32'({oe, outs, osd, err_pin}), 32'h7);
      rd(`FM_OFS_FLAGS, 32'h1 << flag[k]);
      wr(`FM_OFS_CLEAR, 32'h1);
      rd(`FM_OFS_FLAGS, 32'h0);
    end
    $display("test fault table done");
    wr(`FM_OFS_CTRL, 32'h0501);
    raw <= fault_in_s'(8'h01);
    cyc(10);
    raw <= '0;
    cyc(20);
    rd(`FM_OFS_CTRL, 32'h0);
    rd(`FM_OFS_FLAGS, 32'h60);
    wr(`FM_OFS_CLEAR, 32'h2);
    raw <= fault_in_s'(8'h80);
    cyc(10);
    chk(32'({rail, oe}), 32'h1);
    raw <= '0;
    cyc(20);
    rd(`FM_OFS_FLAGS, 32'h60);
    $display("test lockout and shutdown done");
    give_verdict();
  end
endmodule : test_normal_state_fault_monitor
`default_nettype wire
